/* File: hw/umf_pkg.sv */
`default_nettype none
package umf_pkg;
   // Register word offsets (byte address = 4 * index)
   localparam logic [3:0] ADDR_RX_TX = 4'h0;
   localparam logic [3:0] ADDR_IER = 4'h1;
   localparam logic [3:0] ADDR_IID_FCR = 4'h2;
   localparam logic [3:0] ADDR_LINE_CTRL = 4'h3;
   localparam logic [3:0] ADDR_MCR = 4'h4;
   localparam logic [3:0] ADDR_LSR = 4'h5;
   localparam logic [3:0] ADDR_MSR = 4'h6;
   localparam logic [3:0] ADDR_SCR = 4'h7;
   localparam logic [3:0] ADDR_DIV_LO = 4'h8;
   localparam logic [3:0] ADDR_DIV_HI = 4'h9;
   localparam logic [3:0] ADDR_SPEED = 4'hA;
   localparam logic [3:0] ADDR_EVENT = 4'hB;
   // Field positions
   localparam int MCR_DTR = 0;
   localparam int MCR_RTS = 1;
   localparam int MCR_RING = 2;
   localparam int MCR_IRQ_EN = 3;
   localparam int MCR_LOOP = 4;
   localparam int FCR_EN = 0;
   localparam int FCR_RX_RST = 1;
   localparam int FCR_TX_RST = 2;
   localparam int FCR_DMA = 3;
   localparam int FCR_TRIG_LO = 6;
   localparam int IER_RX = 0;
   localparam int IER_TX = 1;
   localparam int IER_LS = 2;
   localparam int IER_MS = 3;
   localparam int SPEED_HI0 = 6;
   localparam int SPEED_HI1 = 7;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_DIV = 16'h0001;
   // Trigger levels
   localparam logic [4:0] TRIG_1 = 5'h01;
   localparam logic [4:0] TRIG_4 = 5'h04;
   localparam logic [4:0] TRIG_8 = 5'h08;
   localparam logic [4:0] TRIG_14 = 5'h0E;
   localparam logic [4:0] FIFO_DEPTH = 5'h10;
   // Timing: 24 MHz source over 13 gives 1.8461 MHz; 4 characters of 10 bits each
   localparam int SRC_CLK_HZ = 24000000;
   localparam logic [3:0] PREDIV = 4'hC; // 13 minus one
   localparam logic [5:0] TIMEOUT_BITS = 6'h28;
   localparam int BUS_HZ = 20000000;
   // Interrupt identification codes
   localparam logic [3:0] IID_NONE = 4'h1;
   localparam logic [3:0] IID_LS = 4'h6;
   localparam logic [3:0] IID_RX = 4'h4;
   localparam logic [3:0] IID_TMO = 4'hC;
   localparam logic [3:0] IID_TX = 4'h2;
   localparam logic [3:0] IID_MS = 4'h0;
   // Modem input pins, active low
   typedef struct packed {
      logic dcd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } umf_modem_in_s;
   // Receive path events from the serial shifter
   typedef struct packed {
      logic rx_byte;
      logic overrun;
      logic parity;
      logic framing;
      logic brk;
   } umf_rx_evt_s;
endpackage : umf_pkg
`default_nettype wire

/* File: hw/umf_uart_ctrl.sv */
// Operation
// - Loopback routes control bits to status inputs
// - Control bit 3 gates interrupt output
// - Control bit 2 only feeds loopback ring
// - RTS and DTR pins driven inverted
// - Status high nibble shows inverted inputs
// - Carrier, ready, clear deltas latch changes
// - Ring delta on low-to-high ring line
// - FIFO bits 7:6 pick trigger level
// - DMA mode 1 with bit 3 and enable
// - FIFO reset bits self clear
// - FIFO control bit 0 enables FIFO mode
// - Identification bits 7:6 show FIFO mode
// - Identification encodes highest pending source
// - Line status interrupt cleared by read
// - Receive data interrupt follows trigger level
// - Receive timeout after four character times
// - Transmit empty cleared by write or identification read
// - Modem interrupt from change flags, cleared by read
// - Four enable bits gate five sources (timeout shares receive enable), upper zero
// - Prediv 24 MHz, then 16-bit divisor
// - High-speed mode skips pre-divider
// - Scratch register read/write
// - Loopback forces output high, pins inactive
// - Error flags clear on line status read
//
// Our own choices: register access over Avalon-MM and the register addresses.
`default_nettype none
module umf_uart_ctrl (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire umf_pkg::umf_modem_in_s modem_in_i,
   input wire logic serial_input_i,
   input wire logic tx_serial_i,
   input wire umf_pkg::umf_rx_evt_s rx_evt_i,
   input wire logic [7:0] rx_byte_data_i,
   input wire logic tx_byte_taken_i,
   input wire logic src_clk_i,
   output logic rts_n_o,
   output logic dtr_n_o,
   output logic serial_output_o,
   output logic rx_serial_o,
   output logic baud16_tick_o,
   output logic dma_mode1_o,
   output logic [7:0] tx_byte_data_o,
   output logic tx_byte_valid_o,
   output logic irq_o
);
   // Registered state
   logic [7:0] mcr_r, mcr_nxt;
   logic [7:0] ier_r, ier_nxt;
   logic [7:0] fcr_r, fcr_nxt;
   logic [7:0] scr_r, scr_nxt;
   logic [7:0] spd_r, spd_nxt;
   logic [15:0] div_r, div_nxt;
   logic [15:0] bcnt_r, bcnt_nxt;
   logic [3:0] pcnt_r, pcnt_nxt;
   logic [3:0] delta_r, delta_nxt;
   logic [3:0] mprev_r, mprev_nxt;
   logic [3:0] err_r, err_nxt;
   logic [4:0] rxcnt_r, rxcnt_nxt;
   logic [7:0] rxhold_r, rxhold_nxt;
   logic [7:0] txd_r, txd_nxt;
   logic txv_r, txv_nxt;
   logic thre_r, thre_nxt;
   logic tick_r, tick_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [3:0] t16_r, t16_nxt;
   logic [5:0] tmo_r, tmo_nxt;
   logic tmo_flag_r, tmo_flag_nxt;
   // Pin synchroniser stages
   logic [3:0] msync1_r, msync2_r;
   logic sin1_r, sin2_r;
   logic src1_r, src2_r, src3_r;
   // Combinational helpers
   logic loop, fifo_en, wr, rd, src_edge, hs_mode;
   logic [3:0] mstat;
   logic [3:0] iid;
   logic [4:0] trig;
   logic p_ls, p_rx, p_tmo, p_tx, p_ms;
   logic [7:0] wb;

   // Trigger level decode
   function automatic logic [4:0] trig_level(input logic [1:0] sel);
      unique case (sel)
         2'h0: trig_level = umf_pkg::TRIG_1;
         2'h1: trig_level = umf_pkg::TRIG_4;
         2'h2: trig_level = umf_pkg::TRIG_8;
         default: trig_level = umf_pkg::TRIG_14;
      endcase
   endfunction : trig_level

   // Pin synchronisers, two stages each; the source clock has a third stage for edge detect
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         msync1_r <= 4'hF;
         msync2_r <= 4'hF;
         sin1_r <= 1'h1;
         sin2_r <= 1'h1;
         src1_r <= 1'h0;
         src2_r <= 1'h0;
         src3_r <= 1'h0;
      end else begin
         msync1_r <= modem_in_i;
         msync2_r <= msync1_r;
         sin1_r <= serial_input_i;
         sin2_r <= sin1_r;
         src1_r <= src_clk_i;
         src2_r <= src1_r;
         src3_r <= src2_r;
      end
   end

   // Decode and status views
   always_comb begin
      loop = mcr_r[umf_pkg::MCR_LOOP];
      fifo_en = fcr_r[umf_pkg::FCR_EN];
      wr = avs_write_i && !ack_r;
      rd = avs_read_i && !ack_r;
      wb = avs_writedata_i[7:0];
      src_edge = src2_r && !src3_r;
      hs_mode = spd_r[umf_pkg::SPEED_HI0] && spd_r[umf_pkg::SPEED_HI1];
      // DCD, RI, DSR, CTS active high
      if (loop) begin
         mstat = {mcr_r[umf_pkg::MCR_IRQ_EN], mcr_r[umf_pkg::MCR_RING],
                  mcr_r[umf_pkg::MCR_DTR], mcr_r[umf_pkg::MCR_RTS]};
      end else begin
         mstat = ~msync2_r;
      end
      // Receive trigger level, one byte outside FIFO mode
      trig = fifo_en ? trig_level(fcr_r[7:umf_pkg::FCR_TRIG_LO]) : umf_pkg::TRIG_1;
      // Pending sources, each gated by its enable
      p_ls = ier_r[umf_pkg::IER_LS] && (err_r != 4'h0);
      p_rx = ier_r[umf_pkg::IER_RX] && (rxcnt_r >= trig) && (rxcnt_r != 5'h00);
      p_tmo = ier_r[umf_pkg::IER_RX] && fifo_en && tmo_flag_r;
      p_tx = ier_r[umf_pkg::IER_TX] && thre_r;
      p_ms = ier_r[umf_pkg::IER_MS] && (delta_r != 4'h0);
      // Priority encode
      if (p_ls) begin
         iid = umf_pkg::IID_LS;
      end else if (p_rx) begin
         iid = umf_pkg::IID_RX;
      end else if (p_tmo) begin
         iid = umf_pkg::IID_TMO;
      end else if (p_tx) begin
         iid = umf_pkg::IID_TX;
      end else if (p_ms) begin
         iid = umf_pkg::IID_MS;
      end else begin
         iid = umf_pkg::IID_NONE;
      end
   end

   // Register file, flags and counters next state
   always_comb begin
      mcr_nxt = mcr_r;
      ier_nxt = ier_r;
      fcr_nxt = fcr_r;
      fcr_nxt[umf_pkg::FCR_RX_RST] = 1'b0;
      fcr_nxt[umf_pkg::FCR_TX_RST] = 1'b0;
      scr_nxt = scr_r;
      spd_nxt = spd_r;
      div_nxt = div_r;
      txd_nxt = txd_r;
      txv_nxt = txv_r && !tx_byte_taken_i;
      thre_nxt = thre_r || tx_byte_taken_i;
      rxhold_nxt = rxhold_r;
      rxcnt_nxt = rxcnt_r;
      err_nxt = err_r;
      mprev_nxt = mstat;
      delta_nxt = delta_r;
      tmo_nxt = tmo_r;
      tmo_flag_nxt = tmo_flag_r;
      rdata_nxt = 32'h0000_0000;
      ack_nxt = (avs_read_i || avs_write_i) && !ack_r;
      // Bus read effects clear first, so hardware sets below win
      if (rd) begin
         unique case (avs_address_i)
            umf_pkg::ADDR_RX_TX: begin
               rdata_nxt[7:0] = rxhold_r;
               if (rxcnt_r != 5'h00) begin
                  rxcnt_nxt = rxcnt_r - 5'h01;
               end
               tmo_flag_nxt = 1'b0;
               tmo_nxt = 6'h00;
            end
            umf_pkg::ADDR_IER: rdata_nxt[7:0] = {4'h0, ier_r[3:0]};
            umf_pkg::ADDR_IID_FCR: begin
               rdata_nxt[7:0] = {fifo_en, fifo_en, 2'h0, iid};
               if (iid == umf_pkg::IID_TX) begin
                  thre_nxt = 1'b0;
               end
            end
            umf_pkg::ADDR_MCR: rdata_nxt[7:0] = {3'h0, mcr_r[4:0]};
            umf_pkg::ADDR_LSR: begin
               rdata_nxt[7:0] = {1'b0, 1'b0, thre_r, err_r, rxcnt_r != 5'h00};
               err_nxt = 4'h0;
            end
            umf_pkg::ADDR_MSR: begin
               rdata_nxt[7:0] = {mstat, delta_r};
               delta_nxt = 4'h0;
            end
            umf_pkg::ADDR_SCR: rdata_nxt[7:0] = scr_r;
            umf_pkg::ADDR_DIV_LO: rdata_nxt[7:0] = div_r[7:0];
            umf_pkg::ADDR_DIV_HI: rdata_nxt[7:0] = div_r[15:8];
            umf_pkg::ADDR_SPEED: rdata_nxt[7:0] = spd_r;
            umf_pkg::ADDR_EVENT: rdata_nxt[7:0] = {3'h0, rxcnt_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
      // Bus write effects
      if (wr && avs_byteenable_i[0]) begin
         unique case (avs_address_i)
            umf_pkg::ADDR_RX_TX: begin
               txd_nxt = wb;
               txv_nxt = 1'b1;
               thre_nxt = 1'b0;
            end
            umf_pkg::ADDR_IER: ier_nxt = {4'h0, wb[3:0]};
            umf_pkg::ADDR_IID_FCR: begin
               fcr_nxt = wb;
               fcr_nxt[5:4] = 2'h0;
               if (wb[umf_pkg::FCR_RX_RST]) begin
                  rxcnt_nxt = 5'h00;
                  tmo_flag_nxt = 1'b0;
               end
               if (wb[umf_pkg::FCR_TX_RST]) begin
                  txv_nxt = 1'b0;
                  thre_nxt = 1'b1;
               end
            end
            umf_pkg::ADDR_MCR: mcr_nxt = {3'h0, wb[4:0]};
            umf_pkg::ADDR_SCR: scr_nxt = wb;
            umf_pkg::ADDR_DIV_LO: div_nxt[7:0] = wb;
            umf_pkg::ADDR_DIV_HI: div_nxt[15:8] = wb;
            umf_pkg::ADDR_SPEED: spd_nxt = wb;
            default: mcr_nxt = mcr_r;
         endcase
      end
      // Hardware set events win over clears
      if (rx_evt_i.rx_byte) begin
         rxhold_nxt = rx_byte_data_i;
         if (rxcnt_r < (fifo_en ? umf_pkg::FIFO_DEPTH : 5'h01)) begin
            rxcnt_nxt = rxcnt_nxt + 5'h01;
         end
         tmo_nxt = 6'h00;
      end
      err_nxt = err_nxt | {rx_evt_i.brk, rx_evt_i.framing, rx_evt_i.parity, rx_evt_i.overrun};
      // DCD, DSR, CTS any change; RI low-to-high of the ring line
      delta_nxt[3] = delta_nxt[3] | (mstat[3] ^ mprev_r[3]);
      delta_nxt[1] = delta_nxt[1] | (mstat[1] ^ mprev_r[1]);
      delta_nxt[0] = delta_nxt[0] | (mstat[0] ^ mprev_r[0]);
      delta_nxt[2] = delta_nxt[2] | (!mstat[2] && mprev_r[2]);
      // Character timeout counted in bit times
      if (tick_r && fifo_en && (rxcnt_r != 5'h00) && !rx_evt_i.rx_byte && !rd) begin
         t16_nxt = t16_r + 4'h1;
         if (t16_r == 4'hF) begin
            if (tmo_r == umf_pkg::TIMEOUT_BITS - 6'h01) begin
               tmo_flag_nxt = 1'b1;
            end else begin
               tmo_nxt = tmo_r + 6'h01;
            end
         end
      end else begin
         t16_nxt = t16_r;
      end
   end

   // Baud generator: prescale edge then divisor
   always_comb begin
      pcnt_nxt = pcnt_r;
      bcnt_nxt = bcnt_r;
      tick_nxt = 1'b0;
      // One step per pre-divided source edge
      if (src_edge) begin
         if (!hs_mode && pcnt_r != umf_pkg::PREDIV) begin
            pcnt_nxt = pcnt_r + 4'h1;
         end else begin
            pcnt_nxt = 4'h0;
            if (bcnt_r + 16'h0001 >= div_r) begin
               bcnt_nxt = 16'h0000;
               tick_nxt = 1'b1;
            end else begin
               bcnt_nxt = bcnt_r + 16'h0001;
            end
         end
      end
   end

   // State registers
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         // Register file
         mcr_r <= umf_pkg::RST_BYTE;
         ier_r <= umf_pkg::RST_BYTE;
         fcr_r <= umf_pkg::RST_BYTE;
         scr_r <= umf_pkg::RST_BYTE;
         spd_r <= umf_pkg::RST_BYTE;
         div_r <= umf_pkg::RST_DIV;
         bcnt_r <= 16'h0000;
         pcnt_r <= 4'h0;
         // Status flags and receive state
         delta_r <= 4'h0;
         mprev_r <= 4'h0;
         err_r <= 4'h0;
         rxcnt_r <= 5'h00;
         rxhold_r <= 8'h00;
         txd_r <= 8'h00;
         txv_r <= 1'b0;
         thre_r <= 1'b1;
         // Bus answer and timing
         tick_r <= 1'b0;
         ack_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         t16_r <= 4'h0;
         tmo_r <= 6'h00;
         tmo_flag_r <= 1'b0;
      end else begin
         // Register file
         mcr_r <= mcr_nxt;
         ier_r <= ier_nxt;
         fcr_r <= fcr_nxt;
         scr_r <= scr_nxt;
         spd_r <= spd_nxt;
         div_r <= div_nxt;
         bcnt_r <= bcnt_nxt;
         pcnt_r <= pcnt_nxt;
         // Status flags and receive state
         delta_r <= delta_nxt;
         mprev_r <= mprev_nxt;
         err_r <= err_nxt;
         rxcnt_r <= rxcnt_nxt;
         rxhold_r <= rxhold_nxt;
         txd_r <= txd_nxt;
         txv_r <= txv_nxt;
         thre_r <= thre_nxt;
         // Bus answer and timing
         tick_r <= tick_nxt;
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
         t16_r <= t16_nxt;
         tmo_r <= tmo_nxt;
         tmo_flag_r <= tmo_flag_nxt;
      end
   end

   // Outputs
   always_comb begin
      // Bus answer, one wait cycle per request
      avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
      avs_readdata_o = rdata_r;
      // Modem and serial pins
      rts_n_o = loop ? 1'b1 : ~mcr_r[umf_pkg::MCR_RTS];
      dtr_n_o = loop ? 1'b1 : ~mcr_r[umf_pkg::MCR_DTR];
      serial_output_o = loop ? 1'b1 : tx_serial_i;
      rx_serial_o = loop ? tx_serial_i : sin2_r;
      // Shifter, baud and interrupt outputs
      baud16_tick_o = tick_r;
      dma_mode1_o = fcr_r[umf_pkg::FCR_DMA] && fifo_en;
      tx_byte_data_o = txd_r;
      tx_byte_valid_o = txv_r;
      irq_o = mcr_r[umf_pkg::MCR_IRQ_EN] && (iid != umf_pkg::IID_NONE);
   end
endmodule : umf_uart_ctrl
`default_nettype wire

/* File: verif/umf_modem_model.sv */
`default_nettype none
module umf_modem_model (
   input wire logic sys_clk_i,
   output var umf_pkg::umf_modem_in_s modem_in_o,
   output logic serial_input_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle line: handshake pins negated, serial line at mark
   initial begin
      modem_in_o = '1;
      serial_input_o = 1'h1;
   end
   // Moves the active-low handshake pins just after a clock edge
   task automatic drive(input logic [3:0] pins);
      @(posedge sys_clk_i);
      modem_in_o <= pins;
   endtask : drive
endmodule : umf_modem_model
`default_nettype wire

/* File: verif/umf_uart_ctrl_chk.sv */
`default_nettype none
module umf_uart_ctrl_chk (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic tx_serial_i,
   input wire logic rts_n_o,
   input wire logic dtr_n_o,
   input wire logic serial_output_o,
   input wire logic dma_mode1_o,
   input wire logic irq_o
);
   logic [15:0][7:0] sh_r;
   logic [15:0][7:0] sh_nxt;
   logic rd_w;
   logic [7:0] mcr_w;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // Shadow of every byte taken by a bus write
   always_comb begin
      sh_nxt = sh_r;
      if (avs_write_i && avs_waitrequest_o && avs_byteenable_i[0]) begin
         sh_nxt[avs_address_i] = avs_writedata_i[7:0];
      end
   end
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sh_r <= '0;
      end else begin
         sh_r <= sh_nxt;
      end
   end
   // Taken reads and the mirrored modem control byte
   assign rd_w = avs_read_i && avs_waitrequest_o;
   assign mcr_w = sh_r[umf_pkg::ADDR_MCR];
   chk_modem_pins: assert property ({rts_n_o, dtr_n_o} == ({2{mcr_w[4]}} | ~mcr_w[1:0]))
      else $error("handshake pins wrong");
   chk_tx_forced: assert property (serial_output_o == (mcr_w[4] | tx_serial_i))
      else $error("serial output wrong");
   chk_irq_gate: assert property (!mcr_w[3] && !$past(mcr_w[3]) |-> !irq_o)
      else $error("interrupt not gated");
   chk_dma_mode: assert property (dma_mode1_o ==
      (sh_r[umf_pkg::ADDR_IID_FCR][0] & sh_r[umf_pkg::ADDR_IID_FCR][3]))
      else $error("dma mode wrong");
   chk_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("wait state count wrong");
   chk_scratch_rd: assert property (rd_w && avs_address_i == umf_pkg::ADDR_SCR
      |=> avs_readdata_o == {24'h0, sh_r[7]})
      else $error("scratch readback wrong");
   chk_enable_rd: assert property (rd_w && avs_address_i == umf_pkg::ADDR_IER
      |=> avs_readdata_o == {28'h0, sh_r[1][3:0]})
      else $error("enable readback wrong");
   chk_iid_upper: assert property (rd_w && avs_address_i == umf_pkg::ADDR_IID_FCR
      |=> avs_readdata_o[31:4] == {24'h0, {2{sh_r[2][0]}}, 2'h0})
      else $error("identification upper bits wrong");
   chk_loop_status: assert property (rd_w && avs_address_i == umf_pkg::ADDR_MSR && mcr_w[4]
      |=> avs_readdata_o[7:4] == {mcr_w[3], mcr_w[2], mcr_w[0], mcr_w[1]})
      else $error("loopback status wrong");
endmodule : umf_uart_ctrl_chk
bind umf_uart_ctrl umf_uart_ctrl_chk chk_u (.sys_clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
   .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .tx_serial_i, .rts_n_o, .dtr_n_o,
   .serial_output_o, .dma_mode1_o, .irq_o);
`default_nettype wire

/* File: verif/tb.sv */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'h0;
   logic reset_n_i = 1'h0;
   logic avs_read_i = 1'h0;
   logic avs_write_i = 1'h0;
   logic [3:0] avs_address_i = 4'h0;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o, rd;
   umf_pkg::umf_modem_in_s modem_in_i;
   umf_pkg::umf_rx_evt_s rx_evt_i = '0;
   logic [7:0] rx_byte_data_i = 8'h0;
   logic [7:0] tx_byte_data_o;
   logic tx_serial_i = 1'h0;
   logic tx_byte_taken_i = 1'h0;
   logic src_clk_i = 1'h0;
   logic avs_waitrequest_o, serial_input_i, rts_n_o, dtr_n_o, serial_output_o, rx_serial_o;
   logic baud16_tick_o, dma_mode1_o, tx_byte_valid_o, irq_o;
   int num_errors = 0;
   int compares = 0;
   // Bus clock, and a slow source clock of four bus cycles
   always #25 sys_clk_i = ~sys_clk_i;
   always begin
      repeat (2) @(posedge sys_clk_i);
      src_clk_i <= ~src_clk_i;
   end
   umf_uart_ctrl dut_u (.sys_clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
      .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .modem_in_i, .serial_input_i, .tx_serial_i,
      .rx_evt_i, .rx_byte_data_i, .tx_byte_taken_i, .src_clk_i, .rts_n_o, .dtr_n_o, .serial_output_o,
      .rx_serial_o, .baud16_tick_o, .dma_mode1_o, .tx_byte_data_o, .tx_byte_valid_o, .irq_o);
   umf_modem_model mdm_u (.sys_clk_i, .modem_in_o(modem_in_i), .serial_input_o(serial_input_i));
   // Verdict and end of run
   task automatic close_out;
      if (num_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out
   // Comparison and bus helpers
   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %0t got %h expected %h", $time, g, e);
      end
   endtask : ck
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      avs_address_i <= a;
      avs_writedata_i <= {24'h0, d};
      avs_write_i <= w;
      avs_read_i <= ~w;
      // Hold the request until waitrequest is sampled low at a rising edge
      do begin
         @(posedge sys_clk_i);
      end while (avs_waitrequest_o !== 1'h0);
      rd = avs_readdata_o;
      avs_write_i <= 1'h0;
      avs_read_i <= 1'h0;
      @(posedge sys_clk_i);
   endtask : acc
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      acc(1'h1, a, d);
   endtask : wr
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      acc(1'h0, a, 8'h0);
      ck(rd, {24'h0, e});
   endtask : rc
   task automatic evt(input logic [4:0] e, input logic [7:0] d);
      rx_evt_i <= e;
      rx_byte_data_i <= d;
      @(posedge sys_clk_i);
      rx_evt_i <= '0;
      @(posedge sys_clk_i);
   endtask : evt
   // Reset values, scratch, unmapped place and masked write
   task automatic t_regs;
      rc(4'h4, 8'h00);
      rc(4'h1, 8'h00);
      rc(4'h8, 8'h01);
      rc(4'h9, 8'h00);
      rc(4'h2, 8'h01);
      ck({rts_n_o, dtr_n_o, irq_o}, 32'h6);
      wr(4'h7, 8'hA5);
      rc(4'h7, 8'hA5);
      avs_byteenable_i <= 4'h0;
      wr(4'h7, 8'h5A);
      avs_byteenable_i <= 4'hF;
      rc(4'h7, 8'hA5);
      wr(4'hE, 8'hFF);
      rc(4'hE, 8'h00);
      wr(4'h1, 8'hF0);
      rc(4'h1, 8'h00);
   endtask : t_regs
   // Output pins, loopback routing and forced serial output
   task automatic t_pins;
      for (int i = 0; i < 8; i++) begin
         wr(4'h4, 8'(i));
         ck({rts_n_o, dtr_n_o}, {30'h0, ~i[1:0]});
      end
      wr(4'h4, 8'h1B);
      ck({rts_n_o, dtr_n_o, serial_output_o, rx_serial_o}, 32'hE);
      acc(1'h0, 4'h6, 8'h0);
      ck(rd[7:4], 32'hB);
      wr(4'h4, 8'h14);
      acc(1'h0, 4'h6, 8'h0);
      ck(rd[7:4], 32'h4);
      wr(4'h4, 8'h00);
      ck({serial_output_o, rx_serial_o}, 32'h1);
   endtask : t_pins
   // Handshake change flags and the modem interrupt
   task automatic t_modem;
      logic [3:0] pv [5] = '{4'h7, 4'h3, 4'h7, 4'h5, 4'h4};
      logic [7:0] ev [5] = '{8'h88, 8'hC0, 8'h84, 8'hA2, 8'hB1};
      wr(4'h1, 8'h08);
      wr(4'h4, 8'h08);
      repeat (4) @(posedge sys_clk_i);
      acc(1'h0, 4'h6, 8'h0);
      foreach (pv[k]) begin
         mdm_u.drive(pv[k]);
         repeat (4) @(posedge sys_clk_i);
         ck(irq_o, 32'(ev[k][3:0] != 4'h0));
         rc(4'h2, (ev[k][3:0] != 4'h0) ? umf_pkg::IID_MS : umf_pkg::IID_NONE);
         rc(4'h6, ev[k]);
         ck(irq_o, 32'h0);
      end
      wr(4'h4, 8'h00);
      mdm_u.drive(4'hF);
      repeat (4) @(posedge sys_clk_i);
      ck(irq_o, 32'h0);
      rc(4'h2, umf_pkg::IID_MS);
      rc(4'h6, 8'h0B);
   endtask : t_modem
   // Transmit empty and line status sources with priority
   task automatic t_sources;
      wr(4'h4, 8'h08);
      wr(4'h1, 8'h02);
      ck(irq_o, 32'h1);
      rc(4'h2, umf_pkg::IID_TX);
      rc(4'h2, umf_pkg::IID_NONE);
      tx_byte_taken_i <= 1'h1;
      @(posedge sys_clk_i);
      tx_byte_taken_i <= 1'h0;
      wr(4'h0, 8'h96);
      rc(4'h2, umf_pkg::IID_NONE);
      ck({tx_byte_valid_o, tx_byte_data_o}, 32'h196);
      tx_byte_taken_i <= 1'h1;
      @(posedge sys_clk_i);
      tx_byte_taken_i <= 1'h0;
      wr(4'h1, 8'h06);
      for (int k = 0; k < 4; k++) begin
         evt(5'(8 >> k), 8'h00);
         rc(4'h2, umf_pkg::IID_LS);
         acc(1'h0, 4'h5, 8'h0);
         ck(rd[4:1], 32'(1 << k));
         acc(1'h0, 4'h5, 8'h0);
         ck(rd[4:1], 32'h0);
      end
      rc(4'h2, umf_pkg::IID_TX);
      rc(4'h2, umf_pkg::IID_NONE);
   endtask : t_sources
   // Trigger levels, receive reset, dma mode and receive timeout
   task automatic t_fifo;
      int lv [4] = '{1, 4, 8, 14};
      wr(4'h1, 8'h01);
      foreach (lv[c]) begin
         wr(4'h2, {2'(c), 6'h03});
         for (int n = 1; n <= lv[c]; n++) begin
            if (n == lv[c]) rc(4'h2, 8'hC1);
            evt(5'h10, 8'(n));
         end
         rc(4'h2, 8'hC4);
         rc(4'h0, 8'(lv[c]));
         rc(4'h2, 8'hC1);
      end
      wr(4'h2, 8'h0B);
      ck(dma_mode1_o, 32'h1);
      wr(4'h2, 8'h08);
      ck(dma_mode1_o, 32'h0);
      rc(4'h2, umf_pkg::IID_NONE);
      wr(4'hA, 8'hC0);
      wr(4'h2, 8'h43);
      evt(5'h10, 8'h77);
      rc(4'h2, 8'hC1);
      for (int n = 0; n < 2000 && rd[7:0] != 8'hCC; n++) acc(1'h0, 4'h2, 8'h0);
      ck(rd, 32'hCC);
      rc(4'h0, 8'h77);
      rc(4'h2, 8'hC1);
   endtask : t_fifo
   // Tick spacing for both speeds and both divisor bytes
   task automatic t_baud;
      logic [7:0] sp [3] = '{8'hC0, 8'h00, 8'hC0};
      logic [15:0] dv [3] = '{16'h0003, 16'h0002, 16'h0100};
      int ex [3] = '{12, 104, 1024};
      int g;
      foreach (sp[k]) begin
         wr(4'hA, sp[k]);
         wr(4'h8, dv[k][7:0]);
         wr(4'h9, dv[k][15:8]);
         repeat (2) begin
            g = 0;
            @(posedge sys_clk_i iff baud16_tick_o);
            do begin
               @(posedge sys_clk_i);
               g++;
            end while (baud16_tick_o !== 1'h1 && g < 3000);
         end
         ck(g, ex[k]);
      end
   endtask : t_baud
   // Main sequence
   initial begin
      repeat (20) @(posedge sys_clk_i);
      reset_n_i <= 1'h1;
      t_regs();
      t_pins();
      t_modem();
      t_sources();
      t_fifo();
      t_baud();
      close_out();
   end
   // Watchdog
   initial begin
      repeat (60000) @(posedge sys_clk_i);
      num_errors++;
      $display("mismatch %0t watchdog expired", $time);
      close_out();
   end
endmodule : tb
`default_nettype wire
